// >>> pio_pkg.sv
// Package with register map, field positions and reset values of the port block.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pio_pkg;
  localparam int unsigned APB_ADDR_W = 8;
  localparam int unsigned IDX_W = 6;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_PORT_B_PIN_LEVELS = 6'h03;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PORT_B_OUTPUT_VALUE = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PORT_C_PIN_LEVELS = 6'h06;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 6'h07;
  localparam logic [IDX_W-1:0] IDX_PORT_C_OUTPUT_VALUE = 6'h08;
  localparam logic [IDX_W-1:0] IDX_PORT_D_PIN_LEVELS = 6'h09;
  localparam logic [IDX_W-1:0] IDX_PORT_D_DIRECTION = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_PORT_D_OUTPUT_VALUE = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_MCU_CONTROL = 6'h35;
  // Port widths.
  localparam int unsigned PORT_B_W = 8;
  localparam int unsigned PORT_C_W = 7;
  localparam int unsigned PORT_D_W = 8;
  // Reset values.
  localparam logic [7:0] RST_PORT_B = 8'h00;
  localparam logic [6:0] RST_PORT_C = 7'h00;
  localparam logic [7:0] RST_PORT_D = 8'h00;
  localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
  // Control register fields.
  localparam int unsigned MCU_PULLUP_OFF_BIT = 4;
  localparam logic [7:0] MCU_WRITE_MASK = 8'h73;
endpackage : pio_pkg

// >>> pio_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pio_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule : pio_sync

// >>> pio_top.sv
// Three I/O ports with APB registers and alternate-function overrides on port D.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module pio_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pio_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pio_pkg::PORT_B_W-1:0] pb_pin_in,
  output logic [pio_pkg::PORT_B_W-1:0] pb_pin_out,
  output logic [pio_pkg::PORT_B_W-1:0] pb_pin_oe_n,
  output logic [pio_pkg::PORT_B_W-1:0] pb_pullup_on,
  input wire logic [pio_pkg::PORT_C_W-1:0] pc_pin_in,
  output logic [pio_pkg::PORT_C_W-1:0] pc_pin_out,
  output logic [pio_pkg::PORT_C_W-1:0] pc_pin_oe_n,
  output logic [pio_pkg::PORT_C_W-1:0] pc_pullup_on,
  input wire logic [pio_pkg::PORT_D_W-1:0] pd_pin_in,
  output logic [pio_pkg::PORT_D_W-1:0] pd_pin_out,
  output logic [pio_pkg::PORT_D_W-1:0] pd_pin_oe_n,
  output logic [pio_pkg::PORT_D_W-1:0] pd_pullup_on,
  input wire logic digital_inputs_off,
  input wire logic serial_receiver_on,
  input wire logic serial_transmitter_on,
  input wire logic serial_tx_data,
  input wire logic serial_sync_select,
  input wire logic serial_ext_clock_out,
  input wire logic timer_zero_compare_on_a,
  input wire logic timer_zero_compare_out_a,
  input wire logic timer_zero_compare_on_b,
  input wire logic timer_zero_compare_out_b,
  input wire logic timer_two_compare_on_b,
  input wire logic timer_two_compare_out_b,
  input wire logic external_irq_zero_on,
  input wire logic external_irq_one_on,
  input wire logic [pio_pkg::PORT_D_W-1:0] pin_change_mask_d,
  input wire logic pin_change_group1_on,
  input wire logic pin_change_group2_on,
  output logic [pio_pkg::PORT_D_W-1:0] pin_change_src_d,
  output logic serial_rx_data,
  output logic serial_ext_clock,
  output logic timer_zero_count_input,
  output logic timer_one_count_input,
  output logic external_irq_zero,
  output logic external_irq_one
);
  localparam int unsigned BW = pio_pkg::PORT_B_W;
  localparam int unsigned CW = pio_pkg::PORT_C_W;
  localparam int unsigned DW = pio_pkg::PORT_D_W;

  //----------------------------------------------------------------------------
  // Register file and APB slave
  //----------------------------------------------------------------------------
  logic [BW-1:0] port_b_direction_reg, port_b_direction_next;
  logic [BW-1:0] port_b_output_value_reg, port_b_output_value_next;
  logic [CW-1:0] port_c_direction_reg, port_c_direction_next;
  logic [CW-1:0] port_c_output_value_reg, port_c_output_value_next;
  logic [DW-1:0] port_d_direction_reg, port_d_direction_next;
  logic [DW-1:0] port_d_output_value_reg, port_d_output_value_next;
  logic [7:0] mcu_control_reg, mcu_control_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [BW-1:0] pb_level;
  logic [CW-1:0] pc_level;
  logic [DW-1:0] pd_level;
  logic [BW-1:0] pb_di;
  logic [CW-1:0] pc_di;
  logic [DW-1:0] pd_di;
  logic [pio_pkg::IDX_W-1:0] idx;
  logic setup;
  logic wr_en;
  logic hit;
  logic global_pullup_off;

  assign idx = paddr[pio_pkg::APB_ADDR_W-1:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_reg;
  assign global_pullup_off = mcu_control_reg[pio_pkg::MCU_PULLUP_OFF_BIT];

  always_comb begin
    port_b_direction_next = port_b_direction_reg;
    port_b_output_value_next = port_b_output_value_reg;
    port_c_direction_next = port_c_direction_reg;
    port_c_output_value_next = port_c_output_value_reg;
    port_d_direction_next = port_d_direction_reg;
    port_d_output_value_next = port_d_output_value_reg;
    mcu_control_next = mcu_control_reg;
    prdata_next = prdata_reg;
    hit = (paddr[1:0] == 2'h0);
    // Writes to the pin-level registers fall through and change nothing.
    if (wr_en && hit) begin
      unique case (idx)
        pio_pkg::IDX_PORT_B_DIRECTION: port_b_direction_next = pwdata[BW-1:0];
        pio_pkg::IDX_PORT_B_OUTPUT_VALUE: port_b_output_value_next = pwdata[BW-1:0];
        pio_pkg::IDX_PORT_C_DIRECTION: port_c_direction_next = pwdata[CW-1:0];
        pio_pkg::IDX_PORT_C_OUTPUT_VALUE: port_c_output_value_next = pwdata[CW-1:0];
        pio_pkg::IDX_PORT_D_DIRECTION: port_d_direction_next = pwdata[DW-1:0];
        pio_pkg::IDX_PORT_D_OUTPUT_VALUE: port_d_output_value_next = pwdata[DW-1:0];
        pio_pkg::IDX_MCU_CONTROL: mcu_control_next = pwdata[7:0] & pio_pkg::MCU_WRITE_MASK;
        default: mcu_control_next = mcu_control_reg;
      endcase
    end
    if (setup) begin
      prdata_next = 32'h0000_0000;
      unique case (idx)
        pio_pkg::IDX_PORT_B_PIN_LEVELS: prdata_next[BW-1:0] = pb_di;
        pio_pkg::IDX_PORT_B_DIRECTION: prdata_next[BW-1:0] = port_b_direction_reg;
        pio_pkg::IDX_PORT_B_OUTPUT_VALUE: prdata_next[BW-1:0] = port_b_output_value_reg;
        pio_pkg::IDX_PORT_C_PIN_LEVELS: prdata_next[CW-1:0] = pc_di;
        pio_pkg::IDX_PORT_C_DIRECTION: prdata_next[CW-1:0] = port_c_direction_reg;
        pio_pkg::IDX_PORT_C_OUTPUT_VALUE: prdata_next[CW-1:0] = port_c_output_value_reg;
        pio_pkg::IDX_PORT_D_PIN_LEVELS: prdata_next[DW-1:0] = pd_di;
        pio_pkg::IDX_PORT_D_DIRECTION: prdata_next[DW-1:0] = port_d_direction_reg;
        pio_pkg::IDX_PORT_D_OUTPUT_VALUE: prdata_next[DW-1:0] = port_d_output_value_reg;
        pio_pkg::IDX_MCU_CONTROL: prdata_next[7:0] = mcu_control_reg;
        default: hit = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0) begin
        hit = 1'b0;
      end
      if (!hit) begin
        prdata_next = 32'h0000_0000;
      end
    end
    // The answer is prepared in the setup cycle so the access phase needs no wait.
    pready_next = setup;
    pslverr_next = setup ? !hit : pslverr_reg && psel && penable;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_b_direction_reg <= pio_pkg::RST_PORT_B;
      port_b_output_value_reg <= pio_pkg::RST_PORT_B;
      port_c_direction_reg <= pio_pkg::RST_PORT_C;
      port_c_output_value_reg <= pio_pkg::RST_PORT_C;
      port_d_direction_reg <= pio_pkg::RST_PORT_D;
      port_d_output_value_reg <= pio_pkg::RST_PORT_D;
      mcu_control_reg <= pio_pkg::RST_MCU_CONTROL;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      port_b_direction_reg <= port_b_direction_next;
      port_b_output_value_reg <= port_b_output_value_next;
      port_c_direction_reg <= port_c_direction_next;
      port_c_output_value_reg <= port_c_output_value_next;
      port_d_direction_reg <= port_d_direction_next;
      port_d_output_value_reg <= port_d_output_value_next;
      mcu_control_reg <= mcu_control_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  //----------------------------------------------------------------------------
  // Input synchronisers and digital input enables
  //----------------------------------------------------------------------------
  pio_sync #(.W(BW)) u_sync_b (.clk(clk), .nrst(nrst), .pin_in(pb_pin_in), .level(pb_level));
  pio_sync #(.W(CW)) u_sync_c (.clk(clk), .nrst(nrst), .pin_in(pc_pin_in), .level(pc_level));
  pio_sync #(.W(DW)) u_sync_d (.clk(clk), .nrst(nrst), .pin_in(pd_pin_in), .level(pd_level));

  //----------------------------------------------------------------------------
  // Port D override pairs and pin drive
  //----------------------------------------------------------------------------
  logic [DW-1:0] pullup_override_on, pullup_override_value;
  logic [DW-1:0] direction_override_on, direction_override_value;
  logic [DW-1:0] out_value_override_on, out_value_override_value;
  logic [DW-1:0] input_enable_override_on, input_enable_override_value;
  logic [DW-1:0] pd_dir, pd_out, pd_pull, pd_die;
  logic [BW-1:0] pb_pin_out_next, pb_pin_oe_n_next, pb_pullup_on_next;
  logic [CW-1:0] pc_pin_out_next, pc_pin_oe_n_next, pc_pullup_on_next;
  logic [DW-1:0] pd_pin_out_next, pd_pin_oe_n_next, pd_pullup_on_next;
  logic [BW-1:0] pb_pin_out_reg, pb_pin_oe_n_reg, pb_pullup_on_reg;
  logic [CW-1:0] pc_pin_out_reg, pc_pin_oe_n_reg, pc_pullup_on_reg;
  logic [DW-1:0] pd_pin_out_reg, pd_pin_oe_n_reg, pd_pullup_on_reg;
  logic [DW-1:0] pd_di_reg;

  always_comb begin
    pullup_override_on = '0;
    pullup_override_value = '0;
    direction_override_on = '0;
    direction_override_value = '0;
    out_value_override_on = '0;
    out_value_override_value = '0;
    // Masked pin-change sources unmask the input buffer under group two, bit 2 under group one instead; value is always one.
    input_enable_override_on = pin_change_mask_d & {DW{pin_change_group2_on}};
    input_enable_override_value = '1;
    pullup_override_on[0] = serial_receiver_on;
    pullup_override_value[0] = port_d_output_value_reg[0] && !global_pullup_off;
    direction_override_on[0] = serial_receiver_on;
    direction_override_value[0] = 1'b0;
    pullup_override_on[1] = serial_transmitter_on;
    direction_override_on[1] = serial_transmitter_on;
    direction_override_value[1] = 1'b1;
    out_value_override_on[1] = serial_transmitter_on;
    out_value_override_value[1] = serial_tx_data;
    input_enable_override_on[2] = external_irq_zero_on ||
                                  (pin_change_mask_d[2] && pin_change_group1_on);
    input_enable_override_on[3] = external_irq_one_on ||
                                  (pin_change_mask_d[3] && pin_change_group2_on);
    out_value_override_on[3] = timer_two_compare_on_b;
    out_value_override_value[3] = timer_two_compare_out_b;
    out_value_override_on[4] = serial_sync_select;
    out_value_override_value[4] = serial_ext_clock_out;
    out_value_override_on[5] = timer_zero_compare_on_b;
    out_value_override_value[5] = timer_zero_compare_out_b;
    out_value_override_on[6] = timer_zero_compare_on_a;
    out_value_override_value[6] = timer_zero_compare_out_a;
    for (int i = 0; i < DW; i++) begin
      pd_dir[i] = direction_override_on[i] ? direction_override_value[i]
                                           : port_d_direction_reg[i];
      pd_out[i] = out_value_override_on[i] ? out_value_override_value[i]
                                           : port_d_output_value_reg[i];
      pd_pull[i] = pullup_override_on[i] ? pullup_override_value[i]
                 : !port_d_direction_reg[i] && port_d_output_value_reg[i]
                   && !global_pullup_off;
      pd_die[i] = input_enable_override_on[i] ? input_enable_override_value[i]
                                              : !digital_inputs_off;
    end
    pb_di = pb_level & {BW{!digital_inputs_off}};
    pc_di = pc_level & {CW{!digital_inputs_off}};
    pd_di = pd_level & pd_die;
    pb_pin_out_next = port_b_output_value_reg;
    pb_pin_oe_n_next = ~port_b_direction_reg;
    pb_pullup_on_next = ~port_b_direction_reg & port_b_output_value_reg
                        & {BW{!global_pullup_off}};
    pc_pin_out_next = port_c_output_value_reg;
    pc_pin_oe_n_next = ~port_c_direction_reg;
    pc_pullup_on_next = ~port_c_direction_reg & port_c_output_value_reg
                        & {CW{!global_pullup_off}};
    pd_pin_out_next = pd_out;
    pd_pin_oe_n_next = ~pd_dir;
    pd_pullup_on_next = pd_pull;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pb_pin_out_reg <= '0;
      pb_pin_oe_n_reg <= '1;
      pb_pullup_on_reg <= '0;
      pc_pin_out_reg <= '0;
      pc_pin_oe_n_reg <= '1;
      pc_pullup_on_reg <= '0;
      pd_pin_out_reg <= '0;
      pd_pin_oe_n_reg <= '1;
      pd_pullup_on_reg <= '0;
      pd_di_reg <= '0;
    end else begin
      pb_pin_out_reg <= pb_pin_out_next;
      pb_pin_oe_n_reg <= pb_pin_oe_n_next;
      pb_pullup_on_reg <= pb_pullup_on_next;
      pc_pin_out_reg <= pc_pin_out_next;
      pc_pin_oe_n_reg <= pc_pin_oe_n_next;
      pc_pullup_on_reg <= pc_pullup_on_next;
      pd_pin_out_reg <= pd_pin_out_next;
      pd_pin_oe_n_reg <= pd_pin_oe_n_next;
      pd_pullup_on_reg <= pd_pullup_on_next;
      pd_di_reg <= pd_di;
    end
  end

  assign pb_pin_out = pb_pin_out_reg;
  assign pb_pin_oe_n = pb_pin_oe_n_reg;
  assign pb_pullup_on = pb_pullup_on_reg;
  assign pc_pin_out = pc_pin_out_reg;
  assign pc_pin_oe_n = pc_pin_oe_n_reg;
  assign pc_pullup_on = pc_pullup_on_reg;
  assign pd_pin_out = pd_pin_out_reg;
  assign pd_pin_oe_n = pd_pin_oe_n_reg;
  assign pd_pullup_on = pd_pullup_on_reg;
  assign pin_change_src_d = pd_di_reg;
  assign serial_rx_data = pd_di_reg[0];
  assign external_irq_zero = pd_di_reg[2];
  assign external_irq_one = pd_di_reg[3];
  assign serial_ext_clock = pd_di_reg[4];
  assign timer_zero_count_input = pd_di_reg[4];
  assign timer_one_count_input = pd_di_reg[5];

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_rx_forces_input: assert property (serial_receiver_on |=> pd_pin_oe_n[0])
    else $error("receive pin not forced to input");
  chk_rx_pullup_follows: assert property (serial_receiver_on |=> pd_pullup_on[0] ==
      ($past(port_d_output_value_reg[0]) && !$past(global_pullup_off)))
    else $error("receive pin pull-up does not follow its port bit");
  chk_pin_change_source_16_route: assert property (##1 pin_change_src_d[0] == $past(pd_di[0]))
    else $error("pin-change source sixteen not fed from port D bit 0");
  chk_pud_kills_all: assert property (global_pullup_off && !serial_transmitter_on |=>
      pb_pullup_on == '0 && pc_pullup_on == '0 && pd_pullup_on == '0)
    else $error("pull-up active while globally disabled");
  chk_xck_value_select: assert property (serial_sync_select |=>
      pd_pin_out[4] == $past(serial_ext_clock_out))
    else $error("serial clock output not driven on port D bit 4");
  chk_no_override_value: assert property (!timer_zero_compare_on_a |=>
      pd_pin_out[6] == $past(port_d_output_value_reg[6]))
    else $error("port D bit 6 value not from port register");
  chk_bit4_fanout: assert property (serial_ext_clock == timer_zero_count_input &&
      serial_ext_clock == pin_change_src_d[4])
    else $error("port D bit 4 input not shared by its three users");
  chk_external_irq_one_input_on: assert property (external_irq_one_on && pd_level[3] |=>
      external_irq_one)
    else $error("irq one input gated off while enabled");
  chk_external_irq_zero_input_on: assert property (pin_change_mask_d[2] && pin_change_group1_on |=>
      external_irq_zero == $past(pd_level[2]))
    else $error("port D bit 2 input gated off while source eighteen is active");
  chk_tx_drives_pin: assert property (serial_transmitter_on |=> !pd_pin_oe_n[1] &&
      !pd_pullup_on[1] && pd_pin_out[1] == $past(serial_tx_data))
    else $error("transmit pin not driven from serial data");
  chk_pin_read_value: assert property (setup && !pwrite && paddr ==
      {pio_pkg::IDX_PORT_D_PIN_LEVELS, 2'h0} |=> prdata[7:0] == $past(pd_di))
    else $error("port D level read returns wrong value");

  cov_rx_and_tx: cover property (serial_receiver_on && serial_transmitter_on);
  cov_reg_write: cover property (wr_en && idx == pio_pkg::IDX_MCU_CONTROL);
  cov_pin_read: cover property (pready && !pwrite && idx == pio_pkg::IDX_PORT_D_PIN_LEVELS);
  cov_bad_addr: cover property (pready && pslverr);
endmodule : pio_top

// >>> pio_pins.sv
// Pin model: outside drivers, pull-ups and floating lines of one port.
`timescale 1ns/1ps
module pio_pins #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] pullup_on,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_in
);
  logic [W-1:0] drift = '0;
  // A pin that nobody drives and no pull-up holds wanders every cycle.
  always @(posedge clk) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = drift[i];
    end
  end
endmodule : pio_pins

// >>> pio_top_bench.sv
// Self-checking bench for the port block with pin models on all three ports.
`timescale 1ns/1ps
module pio_top_bench;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic pready, pslverr, e, rx, sclk, cnt0, cnt1, i0, i1;
  logic [7:0] pb_in, pb_out, pb_oe_n, pb_pu, pd_in, pd_out, pd_oe_n, pd_pu, pcsrc;
  logic [6:0] pc_in, pc_out, pc_oe_n, pc_pu, ext_c = 7'h00;
  logic [7:0] ext_b = 8'h00, ext_d = 8'h00, mask = 8'h00;
  logic [7:0] en_b = 8'hff, en_d = 8'hff;
  logic [6:0] en_c = 7'h7f;
  logic dio = 0, rxon = 0, txon = 0, tx_bit = 0, ssel = 0, xck_o = 0, c0a_on = 0, c0a = 0;
  logic c0b_on = 0, c0b = 0, c2b_on = 0, c2b = 0, i0on = 0, i1on = 0, g1 = 0, g2 = 0;
  int n_errors = 0, samples_checked = 0, seed = 7857;
  always #2.5 clk = ~clk;
  pio_top DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_pin_oe_n(pb_oe_n), .pb_pullup_on(pb_pu),
    .pc_pin_in(pc_in), .pc_pin_out(pc_out), .pc_pin_oe_n(pc_oe_n), .pc_pullup_on(pc_pu),
    .pd_pin_in(pd_in), .pd_pin_out(pd_out), .pd_pin_oe_n(pd_oe_n), .pd_pullup_on(pd_pu),
    .digital_inputs_off(dio), .serial_receiver_on(rxon), .serial_transmitter_on(txon),
    .serial_tx_data(tx_bit), .serial_sync_select(ssel), .serial_ext_clock_out(xck_o),
    .timer_zero_compare_on_a(c0a_on), .timer_zero_compare_out_a(c0a),
    .timer_zero_compare_on_b(c0b_on), .timer_zero_compare_out_b(c0b),
    .timer_two_compare_on_b(c2b_on), .timer_two_compare_out_b(c2b),
    .external_irq_zero_on(i0on), .external_irq_one_on(i1on), .pin_change_mask_d(mask),
    .pin_change_group1_on(g1), .pin_change_group2_on(g2), .pin_change_src_d(pcsrc),
    .serial_rx_data(rx), .serial_ext_clock(sclk), .timer_zero_count_input(cnt0),
    .timer_one_count_input(cnt1), .external_irq_zero(i0), .external_irq_one(i1));
  pio_pins #(.W(8)) pins_b (.clk(clk), .pin_out(pb_out), .pin_oe_n(pb_oe_n),
    .pullup_on(pb_pu), .ext_en(en_b), .ext_val(ext_b), .pin_in(pb_in));
  pio_pins #(.W(7)) pins_c (.clk(clk), .pin_out(pc_out), .pin_oe_n(pc_oe_n),
    .pullup_on(pc_pu), .ext_en(en_c), .ext_val(ext_c), .pin_in(pc_in));
  pio_pins #(.W(8)) pins_d (.clk(clk), .pin_out(pd_out), .pin_oe_n(pd_oe_n),
    .pullup_on(pd_pu), .ext_en(en_d), .ext_val(ext_d), .pin_in(pd_in));
  //----------------------------------------------------------------------------
  // Expectations and bus tasks
  //----------------------------------------------------------------------------
  function automatic logic [7:0] pu_exp(input logic [7:0] dir, out, input logic off);
    return ~dir & out & {8{~off}};
  endfunction : pu_exp
  // A released input pin reads its pull-up, so the stimulus only releases pins with one.
  function automatic logic [7:0] lvl_exp(input logic [7:0] dir, out, en, ext);
    return (dir & out) | (~dir & en & ext) | (~dir & ~en & out);
  endfunction : lvl_exp
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask : wr
  task automatic rd(input logic [5:0] i);
    apb(1'b0, {i, 2'b00}, 32'h0);
  endtask : rd
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : go
  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    chk("oe_n after reset", {24'h0, pd_oe_n}, 32'hff);
    for (int k = 3; k < 12; k++) begin
      rd(6'(k));
      chk("reset value", r, 32'h0);
    end
    rd(pio_pkg::IDX_MCU_CONTROL);
    chk("control reset", r, 32'h0);
    apb(1'b1, 8'h29, 32'hff);
    chk("misaligned error", {31'h0, e}, 32'h1);
    rd(pio_pkg::IDX_PORT_D_DIRECTION);
    chk("misaligned no write", r, 32'h0);
    rd(6'h3f);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    repeat (8) begin
      v = $random(seed);
      wr(pio_pkg::IDX_PORT_B_DIRECTION, v[7:0]);
      wr(pio_pkg::IDX_PORT_B_OUTPUT_VALUE, v[15:8]);
      wr(pio_pkg::IDX_MCU_CONTROL, v[23:16]);
      wr(pio_pkg::IDX_PORT_C_DIRECTION, v[31:24]);
      wr(pio_pkg::IDX_PORT_C_OUTPUT_VALUE, v[15:8]);
      go(2);
      chk("b pullup", pb_pu, pu_exp(v[7:0], v[15:8], v[20]));
      chk("b oe_n", pb_oe_n, {24'h0, ~v[7:0]});
      chk("b out", pb_out, {24'h0, v[15:8]});
      chk("c pullup", pc_pu, pu_exp({1'b0, v[30:24]}, {1'b0, v[14:8]}, v[20]));
      chk("c oe_n", pc_oe_n, {25'h0, ~v[30:24]});
      chk("c out", pc_out, {25'h0, v[14:8]});
      rd(pio_pkg::IDX_MCU_CONTROL);
      chk("control", r, {24'h0, v[23:16] & 8'h73});
      rd(pio_pkg::IDX_PORT_C_DIRECTION);
      chk("c dir", r, {25'h0, v[30:24]});
    end
    wr(pio_pkg::IDX_MCU_CONTROL, 32'h0);
    repeat (4) begin
      v = $random(seed);
      wr(pio_pkg::IDX_PORT_B_DIRECTION, v[7:0]);
      wr(pio_pkg::IDX_PORT_B_OUTPUT_VALUE, v[15:8]);
      @(posedge clk);
      ext_b <= v[23:16];
      en_b <= v[31:24] | ~v[15:8];
      go(6);
      rd(pio_pkg::IDX_PORT_B_PIN_LEVELS);
      chk("b levels", r, lvl_exp(v[7:0], v[15:8], v[31:24] | ~v[15:8], v[23:16]));
      wr(pio_pkg::IDX_PORT_B_PIN_LEVELS, ~v);
      rd(pio_pkg::IDX_PORT_B_DIRECTION);
      chk("dir after level write", r, {24'h0, v[7:0]});
    end
    wr(pio_pkg::IDX_PORT_D_DIRECTION, 32'h69);
    @(posedge clk);
    rxon <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(pio_pkg::IDX_MCU_CONTROL, {27'h0, k[1], 4'h0});
      wr(pio_pkg::IDX_PORT_D_OUTPUT_VALUE, {30'h0, 1'b1, k[0]});
      go(2);
      chk("rx oe_n", pd_oe_n[0], 1'b1);
      chk("rx pullup", pd_pu[0], k[0] & ~k[1]);
    end
    wr(pio_pkg::IDX_MCU_CONTROL, 32'h0);
    @(posedge clk);
    rxon <= 1'b0;
    go(2);
    chk("plain oe_n", pd_oe_n[1:0], 2'b10);
    chk("plain pullup", pd_pu[1], 1'b1);
    repeat (4) begin
      v = $random(seed);
      @(posedge clk);
      txon <= 1'b1;
      tx_bit <= v[0];
      go(2);
      chk("tx pin", {pd_oe_n[1], pd_out[1], pd_pu[1]}, {1'b0, v[0], 1'b0});
    end
    @(posedge clk);
    txon <= 1'b0;
    wr(pio_pkg::IDX_PORT_D_DIRECTION, 32'h0);
    repeat (4) begin
      v = $random(seed);
      @(posedge clk);
      ext_d <= v[7:0];
      go(7);
      chk("change sources", pcsrc, v[7:0]);
      chk("rx data", rx, v[0]);
      chk("clock and counts", {sclk, cnt0, cnt1}, {v[4], v[4], v[5]});
      chk("irq levels", {i0, i1}, {v[2], v[3]});
    end
    @(posedge clk);
    ext_d <= 8'hff;
    dio <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      {i1on, i0on, g2, g1, mask[3], mask[2]} <= k[5:0];
      go(6);
      chk("irq one enable", i1, k[5] | (k[3] & k[1]));
      chk("irq zero enable", i0, k[4] | (k[2] & k[0]));
    end
    @(posedge clk);
    dio <= 1'b0;
    wr(pio_pkg::IDX_PORT_D_DIRECTION, 32'h78);
    repeat (4) begin
      v = $random(seed);
      @(posedge clk);
      {c0a_on, c0b_on, c2b_on, ssel} <= 4'hf;
      {c0a, c0b, c2b, xck_o} <= v[3:0];
      go(2);
      chk("override out", pd_out[6:3], {v[3], v[2], v[0], v[1]});
    end
    @(posedge clk);
    {c0a_on, c0b_on, c2b_on, ssel} <= 4'h0;
    go(2);
    chk("register out", pd_out, 32'h03);
    stop_test();
  end
endmodule : pio_top_bench
